// *** src/barb_arbiter.sv ***
/*
  Bus arbiter top: internal and external arbiters, access sequencer,
  external bus release handshake, external and peripheral write buffers,
  Avalon-MM register slave.
  Assumes masters hold request, write, space and hold until their done pulse.
*/
`timescale 1ns/1ps
// Contract
// - Leave bus-released state one cycle after release request pin returns high.
// - While released and cancel output enabled, pull cancel request low on external access.
// - Return cancel request high at rising edge of release acknowledge.
// - ROM read one cycle, ROM write six; RAM read and write one.
// - Peripheral-clock register access inserts zero to n-1 sync cycles.
// - Register groups take their listed internal or peripheral clock counts.
// - General peripheral registers write in two peripheral clocks; only they are buffered.
// - External write buffer works only when its enable bit is set.
// - Buffered external write runs alone two cycles, then overlaps internal accesses.
// - Peripheral write buffer works only when its enable bit is set.
// - Buffered register write runs alone two cycles, then overlaps memory or external.
// - Separate internal and external arbiters; external one also serves release requests.
// - Each arbiter grants highest priority; owner keeps bus until grant withdrawn.
// - External release request outranks any internal master external access.
// - With alternation set, core alternates with back-to-back transfer-unit or DMA cycles.
// - Internal accesses proceed while the external bus is released.
// - Core is lowest priority, yields at cycle end, in sleep every clock.
// - Core keeps the bus through atomic sequences it flags as unbreakable.
// - Transfer unit and DMA win internal arbiter before requesting external one.
// - Transfer unit keeps bus through descriptor and first-transfer phases.
// - DMA keeps bus between dual-address read and write; otherwise yields per cycle.
// - Release request counts only with both enable bits set, after current external cycle.
// - On release, acknowledge goes low and external bus outputs float.
module barb_arbiter (
  input  wire logic        CLK_SYS,
  input  wire logic        RST,
  input  wire logic [3:0]  AVS_ADDRESS,
  input  wire logic        AVS_READ,
  input  wire logic        AVS_WRITE,
  input  wire logic [31:0] AVS_WRITEDATA,
  input  wire logic [3:0]  AVS_BYTEENABLE,
  output logic [31:0]      AVS_READDATA,
  output logic             AVS_WAITREQUEST,
  input  wire logic [2:0]  MST_REQ,
  input  wire logic [2:0]  MST_WRITE,
  input  wire logic [8:0]  MST_SPACE,
  input  wire logic [2:0]  MST_HOLD,
  input  wire logic        CPU_SLEEP,
  input  wire logic        DMA_SINGLE,
  output logic [2:0]       MST_GRANT,
  output logic [2:0]       MST_DONE,
  input  wire logic        EXT_RELEASE_REQUEST_N,
  output logic             RELEASE_ACK_N,
  output logic             RELEASE_CANCEL_REQUEST_N,
  output logic             RELEASE_CANCEL_OE,
  output logic             EXT_BUS_OE
);
  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  localparam int PG_MIN = 9;
  localparam int PG_MAX = 12;

  barb_eng_if ext_if ();
  barb_eng_if per_if ();

  logic [2:0]           ctrl_one_reg;
  logic [1:0]           ctrl_two_reg;
  logic                 pin_ctrl_reg;
  logic                 ack_reg;
  logic [31:0]          rdata_reg;
  logic [31:0]          read_mux;
  logic                 avs_req;
  logic                 wr_go;
  logic                 ext_release_request_n_n_lvl;
  logic                 rel_req;
  logic                 released_reg;
  logic                 released_next;
  logic                 cancel_reg;
  logic                 cancel_next;
  barb_pkg::barb_state_t state_reg;
  logic [2:0]           grant_reg;
  logic [2:0]           grant_next;
  logic [2:0]           done_reg;
  logic                 last_nc_reg;
  logic [4:0]           cnt_reg;
  logic                 sel_ext_reg;
  logic                 buf_reg;
  logic [4:0]           pdiv_cnt_reg;
  logic [4:0]           sync_cyc;
  logic                 cur_req;
  logic                 cur_wr;
  logic [2:0]           cur_sp_raw;
  barb_pkg::barb_space_t cur_sp;
  logic                 is_ext;
  logic                 is_mem;
  logic                 is_per;
  logic                 issue;
  logic                 mem_start;
  logic                 ext_buf;
  logic                 per_buf;
  logic                 wait_ext;
  logic                 hold_keep;
  logic                 eng_end;
  logic [4:0]           cur_len;

  // ----------------------------------------
  // Avalon-MM slave
  // ----------------------------------------
  assign avs_req         = AVS_READ | AVS_WRITE;
  assign AVS_WAITREQUEST = avs_req & ~ack_reg;
  assign AVS_READDATA    = rdata_reg;
  assign wr_go           = AVS_WRITE & ack_reg & AVS_BYTEENABLE[0];

  always_comb begin
    if (AVS_ADDRESS == barb_pkg::OFS_CTRL_ONE) begin
      read_mux = {29'h0, ctrl_one_reg};
    end else if (AVS_ADDRESS == barb_pkg::OFS_CTRL_TWO) begin
      read_mux = {30'h0, ctrl_two_reg};
    end else if (AVS_ADDRESS == barb_pkg::OFS_PIN_CTRL) begin
      read_mux = {31'h0, pin_ctrl_reg};
    end else if (AVS_ADDRESS == barb_pkg::OFS_STATUS) begin
      read_mux = {25'h0, grant_reg, ~per_if.ready, ~ext_if.ready, ~cancel_reg, released_reg};
    end else begin
      read_mux = 32'h0;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      ack_reg   <= 1'b0;
      rdata_reg <= 32'h0;
    end else begin
      ack_reg <= avs_req & ~ack_reg;
      if (avs_req & ~ack_reg) begin
        rdata_reg <= read_mux;
      end
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      ctrl_one_reg <= barb_pkg::RST_CTRL_ONE;
      ctrl_two_reg <= barb_pkg::RST_CTRL_TWO;
      pin_ctrl_reg <= barb_pkg::RST_PIN_CTRL;
    end else if (wr_go) begin
      if (AVS_ADDRESS == barb_pkg::OFS_CTRL_ONE) begin
        ctrl_one_reg <= AVS_WRITEDATA[2:0];
      end else if (AVS_ADDRESS == barb_pkg::OFS_CTRL_TWO) begin
        ctrl_two_reg <= AVS_WRITEDATA[1:0];
      end else if (AVS_ADDRESS == barb_pkg::OFS_PIN_CTRL) begin
        pin_ctrl_reg <= AVS_WRITEDATA[barb_pkg::BIT_PIN_IN_EN];
      end
    end
  end

  // ----------------------------------------
  // Current owner and access length
  // ----------------------------------------
  always_comb begin
    cur_req    = 1'b0;
    cur_wr     = 1'b0;
    cur_sp_raw = 3'h0;
    for (int i = 0; i < 3; i++) begin
      if (grant_reg[i]) begin
        cur_req    = MST_REQ[i];
        cur_wr     = MST_WRITE[i];
        cur_sp_raw = MST_SPACE[3*i +: 3];
      end
    end
  end

  assign cur_sp   = barb_pkg::barb_space_t'(cur_sp_raw);
  assign is_ext   = cur_sp == barb_pkg::SP_EXT;
  assign is_mem   = (cur_sp == barb_pkg::SP_ROM) | (cur_sp == barb_pkg::SP_RAM);
  assign is_per   = ~is_ext & ~is_mem;
  assign sync_cyc = barb_pkg::PER_DIV - 5'h01 - pdiv_cnt_reg;

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      pdiv_cnt_reg <= 5'h00;
    end else if (pdiv_cnt_reg == barb_pkg::PER_DIV - 5'h01) begin
      pdiv_cnt_reg <= 5'h00;
    end else begin
      pdiv_cnt_reg <= pdiv_cnt_reg + 5'h01;
    end
  end

  always_comb begin
    case (cur_sp)
      barb_pkg::SP_ROM:     cur_len = cur_wr ? barb_pkg::CYC_ROM_WR : barb_pkg::CYC_ROM_RD;
      barb_pkg::SP_RAM:     cur_len = barb_pkg::CYC_RAM;
      barb_pkg::SP_DMA_REG: cur_len = barb_pkg::CYC_DMA_REG;
      barb_pkg::SP_SYS_REG: cur_len = cur_wr ? barb_pkg::CYC_SYS_WR : barb_pkg::CYC_SYS_RD;
      barb_pkg::SP_PFC_REG: cur_len = sync_cyc + 5'((cur_wr ? barb_pkg::PCL_PFC_WR : barb_pkg::PCL_PFC_RD)
                                      * barb_pkg::PER_DIV);
      barb_pkg::SP_GEN_REG: cur_len = sync_cyc + 5'(barb_pkg::PCL_GEN * barb_pkg::PER_DIV);
      default:              cur_len = barb_pkg::CYC_EXT;
    endcase
  end

  assign ext_buf = is_ext & ctrl_one_reg[barb_pkg::BIT_EXT_WB_EN]
                 & (cur_wr | ((grant_reg == barb_pkg::GNT_DMA) & DMA_SINGLE));
  assign per_buf = (cur_sp == barb_pkg::SP_GEN_REG) & cur_wr & ctrl_two_reg[barb_pkg::BIT_PER_WB_EN];

  // ----------------------------------------
  // Engines and dispatch
  // ----------------------------------------
  assign issue        = (state_reg == barb_pkg::ST_ISSUE) & cur_req;
  assign mem_start    = issue & is_mem;
  assign per_if.start = issue & is_per & per_if.ready;
  assign per_if.len   = cur_len;
  assign ext_if.start = issue & is_ext & ext_if.ready & ~released_reg & ~rel_req;
  assign ext_if.len   = cur_len;
  assign wait_ext     = issue & is_ext & released_reg;
  assign eng_end      = sel_ext_reg ? (buf_reg ? ext_if.early : ext_if.done)
                                    : (buf_reg ? per_if.early : per_if.done);

  barb_engine u_ext_eng (
    .clk_sys (CLK_SYS),
    .rst     (RST),
    .eng     (ext_if)
  );

  barb_engine u_per_eng (
    .clk_sys (CLK_SYS),
    .rst     (RST),
    .eng     (per_if)
  );

  // ----------------------------------------
  // Internal arbiter
  // ----------------------------------------
  assign hold_keep = |(grant_reg & MST_HOLD & MST_REQ & ~(CPU_SLEEP ? barb_pkg::GNT_CPU : 3'h0));

  always_comb begin
    if (hold_keep) begin
      grant_next = grant_reg;
    end else if (ctrl_two_reg[barb_pkg::BIT_ALT_SEL] & last_nc_reg & MST_REQ[0]) begin
      grant_next = barb_pkg::GNT_CPU;
    end else if (|(MST_REQ & barb_pkg::GNT_DMA)) begin
      grant_next = barb_pkg::GNT_DMA;
    end else if (|(MST_REQ & barb_pkg::GNT_DTU)) begin
      grant_next = barb_pkg::GNT_DTU;
    end else if (|(MST_REQ & barb_pkg::GNT_CPU)) begin
      grant_next = barb_pkg::GNT_CPU;
    end else begin
      grant_next = 3'h0;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      state_reg   <= barb_pkg::ST_IDLE;
      grant_reg   <= 3'h0;
      done_reg    <= 3'h0;
      last_nc_reg <= 1'b0;
      cnt_reg     <= 5'h00;
      sel_ext_reg <= 1'b0;
      buf_reg     <= 1'b0;
    end else begin
      done_reg <= 3'h0;
      case (state_reg)
        barb_pkg::ST_IDLE: begin
          grant_reg <= grant_next;
          if (|grant_next) begin
            state_reg <= barb_pkg::ST_ISSUE;
          end
        end
        barb_pkg::ST_ISSUE: begin
          if (!cur_req) begin
            state_reg <= barb_pkg::ST_IDLE;
          end else if (mem_start) begin
            cnt_reg   <= cur_len;
            state_reg <= barb_pkg::ST_MEM;
          end else if (per_if.start) begin
            sel_ext_reg <= 1'b0;
            buf_reg     <= per_buf;
            state_reg   <= barb_pkg::ST_ENG;
          end else if (ext_if.start) begin
            sel_ext_reg <= 1'b1;
            buf_reg     <= ext_buf;
            state_reg   <= barb_pkg::ST_ENG;
          end
        end
        barb_pkg::ST_MEM: begin
          if (cnt_reg == 5'h01) begin
            state_reg   <= barb_pkg::ST_IDLE;
            done_reg    <= grant_reg;
            last_nc_reg <= ~|(grant_reg & barb_pkg::GNT_CPU);
          end else begin
            cnt_reg <= cnt_reg - 5'h01;
          end
        end
        barb_pkg::ST_ENG: begin
          if (eng_end) begin
            state_reg   <= barb_pkg::ST_IDLE;
            done_reg    <= grant_reg;
            last_nc_reg <= ~|(grant_reg & barb_pkg::GNT_CPU);
          end
        end
        default: state_reg <= barb_pkg::ST_IDLE;
      endcase
    end
  end

  assign MST_GRANT = grant_reg;
  assign MST_DONE  = done_reg;

  // ----------------------------------------
  // External arbiter and bus release
  // ----------------------------------------
  barb_sync3 u_ext_release_request_n_sync (
    .clk_sys   (CLK_SYS),
    .rst       (RST),
    .async_in  (EXT_RELEASE_REQUEST_N),
    .level_out (ext_release_request_n_n_lvl)
  );

  assign rel_req = ~ext_release_request_n_n_lvl & ctrl_one_reg[barb_pkg::BIT_RELEASE_EN] & pin_ctrl_reg;

  always_comb begin
    if (released_reg) begin
      released_next = ~ext_release_request_n_n_lvl;
    end else begin
      released_next = rel_req & ext_if.ready;
    end
    if (released_next) begin
      cancel_next = cancel_reg & ~(ctrl_one_reg[barb_pkg::BIT_CANCEL_OE] & wait_ext);
    end else begin
      cancel_next = 1'b1;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      released_reg <= 1'b0;
      cancel_reg   <= 1'b1;
    end else begin
      released_reg <= released_next;
      cancel_reg   <= cancel_next;
    end
  end

  assign RELEASE_ACK_N            = ~released_reg;
  assign EXT_BUS_OE               = ~released_reg;
  assign RELEASE_CANCEL_REQUEST_N = cancel_reg;
  assign RELEASE_CANCEL_OE        = ctrl_one_reg[barb_pkg::BIT_CANCEL_OE];

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  sequence s_mem_six;
    (state_reg == barb_pkg::ST_MEM) [*6];
  endsequence

  sequence s_back_idle;
    ##1 (state_reg == barb_pkg::ST_IDLE);
  endsequence

  property p_release_exit;
    @(posedge CLK_SYS) disable iff (RST)
    released_reg && ext_release_request_n_n_lvl |=> !released_reg && RELEASE_ACK_N;
  endproperty
  a_release_exit: assert property (p_release_exit) else $error("release not left");

  property p_cancel_low;
    @(posedge CLK_SYS) disable iff (RST)
    released_reg && !ext_release_request_n_n_lvl && RELEASE_CANCEL_OE && wait_ext |=> !RELEASE_CANCEL_REQUEST_N;
  endproperty
  a_cancel_low: assert property (p_cancel_low) else $error("cancel request not driven low");

  property p_cancel_high;
    @(posedge CLK_SYS) disable iff (RST)
    $rose(RELEASE_ACK_N) |-> RELEASE_CANCEL_REQUEST_N;
  endproperty
  a_cancel_high: assert property (p_cancel_high) else $error("cancel request not high with ack");

  property p_rom_write;
    @(posedge CLK_SYS) disable iff (RST)
    mem_start && (cur_sp == barb_pkg::SP_ROM) && cur_wr |=> s_mem_six ##0 s_back_idle;
  endproperty
  a_rom_write: assert property (p_rom_write) else $error("ROM write not six cycles");

  property p_gen_write;
    @(posedge CLK_SYS) disable iff (RST)
    per_if.start && (cur_sp == barb_pkg::SP_GEN_REG) && cur_wr && !per_buf |-> ##[PG_MIN:PG_MAX] (|done_reg);
  endproperty
  a_gen_write: assert property (p_gen_write) else $error("peripheral write length wrong");

  property p_ext_buffer;
    @(posedge CLK_SYS) disable iff (RST)
    ext_if.start && ext_buf |-> ##3 (|done_reg);
  endproperty
  a_ext_buffer: assert property (p_ext_buffer) else $error("buffered external write not freed");

  property p_per_buffer;
    @(posedge CLK_SYS) disable iff (RST)
    per_if.start && per_buf |-> ##3 (|done_reg) && !per_if.ready;
  endproperty
  a_per_buffer: assert property (p_per_buffer) else $error("buffered register write not freed");

  property p_release_priority;
    @(posedge CLK_SYS) disable iff (RST)
    rel_req && issue && is_ext && ext_if.ready && !released_reg |=> released_reg && ext_if.ready;
  endproperty
  a_release_priority: assert property (p_release_priority) else $error("external access beat release");

  property p_release_after_cycle;
    @(posedge CLK_SYS) disable iff (RST)
    $rose(released_reg) |-> $past(ext_if.ready) && !EXT_BUS_OE;
  endproperty
  a_release_after_cycle: assert property (p_release_after_cycle) else $error("released mid cycle");

  property p_hold;
    @(posedge CLK_SYS) disable iff (RST)
    (state_reg == barb_pkg::ST_IDLE) && hold_keep |=> $stable(grant_reg);
  endproperty
  a_hold: assert property (p_hold) else $error("held bus transferred");

  property p_alternate;
    @(posedge CLK_SYS) disable iff (RST)
    (state_reg == barb_pkg::ST_IDLE) && !hold_keep && last_nc_reg && MST_REQ[0]
      && ctrl_two_reg[barb_pkg::BIT_ALT_SEL] |=> (grant_reg == barb_pkg::GNT_CPU);
  endproperty
  a_alternate: assert property (p_alternate) else $error("core not alternated in");

  property p_onehot;
    @(posedge CLK_SYS) disable iff (RST)
    $onehot0(grant_reg) && $onehot0(done_reg);
  endproperty
  a_onehot: assert property (p_onehot) else $error("more than one owner");

  property p_parallel;
    @(posedge CLK_SYS) disable iff (RST)
    released_reg && mem_start |=> (state_reg == barb_pkg::ST_MEM);
  endproperty
  a_parallel: assert property (p_parallel) else $error("internal access blocked by release");
endmodule

// *** src/barb_eng_if.sv ***
/*
  Handshake between the sequencer and one access engine.
  Assumes start is only raised while ready is high.
*/
`timescale 1ns/1ps
interface barb_eng_if;
  logic       start;
  logic [4:0] len;
  logic       ready;
  logic       early;
  logic       done;
  modport host (output start, len, input ready, early, done);
  modport eng  (input start, len, output ready, early, done);
endinterface

// *** src/barb_engine.sv ***
/*
  Access engine: runs one access of a given length, one pending at most.
  Assumes len is at least one and start only while ready.
*/
`timescale 1ns/1ps
module barb_engine (
  input  wire logic clk_sys,
  input  wire logic rst,
  barb_eng_if.eng   eng
);
  logic       busy_reg;
  logic [4:0] cnt_reg;
  logic [4:0] len_reg;
  logic       take;

  assign take      = eng.start & ~busy_reg;
  assign eng.ready = ~busy_reg;
  assign eng.done  = busy_reg & (cnt_reg == len_reg);
  assign eng.early = eng.done | (busy_reg & (cnt_reg >= barb_pkg::CYC_EARLY));

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      busy_reg <= 1'b0;
    end else if (take) begin
      busy_reg <= 1'b1;
    end else if (eng.done) begin
      busy_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      cnt_reg <= 5'h00;
      len_reg <= 5'h00;
    end else if (take) begin
      cnt_reg <= 5'h01;
      len_reg <= eng.len;
    end else if (busy_reg) begin
      cnt_reg <= cnt_reg + 5'h01;
    end
  end

  property p_single_pending;
    @(posedge clk_sys) disable iff (rst)
    busy_reg && !eng.done |=> busy_reg && $stable(len_reg);
  endproperty
  a_single_pending: assert property (p_single_pending) else $error("start while engine busy");
endmodule

// *** src/barb_pkg.sv ***
/*
  Shared constants and types of the bus arbiter with bus release and write buffers.
  Assumes a single system clock; every user writes barb_pkg::name.
*/
package barb_pkg;
  // ----------------------------------------
  // Register offsets and fields
  // ----------------------------------------
  localparam logic [3:0] OFS_CTRL_ONE   = 4'h0;
  localparam logic [3:0] OFS_CTRL_TWO   = 4'h4;
  localparam logic [3:0] OFS_PIN_CTRL   = 4'h8;
  localparam logic [3:0] OFS_STATUS     = 4'hc;
  localparam int         BIT_RELEASE_EN = 0;
  localparam int         BIT_CANCEL_OE  = 1;
  localparam int         BIT_EXT_WB_EN  = 2;
  localparam int         BIT_PER_WB_EN  = 0;
  localparam int         BIT_ALT_SEL    = 1;
  localparam int         BIT_PIN_IN_EN  = 0;
  localparam logic [2:0] RST_CTRL_ONE   = 3'h0;
  localparam logic [1:0] RST_CTRL_TWO   = 2'h0;
  localparam logic       RST_PIN_CTRL   = 1'b0;
  // ----------------------------------------
  // Masters, spaces, states
  // ----------------------------------------
  localparam logic [2:0] GNT_CPU = 3'h1;
  localparam logic [2:0] GNT_DTU = 3'h2;
  localparam logic [2:0] GNT_DMA = 3'h4;
  typedef enum logic [2:0] {
    SP_ROM     = 3'h0,
    SP_RAM     = 3'h1,
    SP_DMA_REG = 3'h2,
    SP_SYS_REG = 3'h3,
    SP_PFC_REG = 3'h4,
    SP_GEN_REG = 3'h5,
    SP_EXT     = 3'h6
  } barb_space_t;
  typedef enum logic [2:0] {
    ST_IDLE  = 3'h0,
    ST_ISSUE = 3'h1,
    ST_MEM   = 3'h2,
    ST_ENG   = 3'h3
  } barb_state_t;
  // ----------------------------------------
  // Cycle counts
  // ----------------------------------------
  localparam logic [4:0] CYC_ROM_RD  = 5'h01;
  localparam logic [4:0] CYC_ROM_WR  = 5'h06;
  localparam logic [4:0] CYC_RAM     = 5'h01;
  localparam logic [4:0] CYC_DMA_REG = 5'h02;
  localparam logic [4:0] CYC_SYS_RD  = 5'h02;
  localparam logic [4:0] CYC_SYS_WR  = 5'h03;
  localparam logic [4:0] PCL_PFC_RD  = 5'h02;
  localparam logic [4:0] PCL_PFC_WR  = 5'h03;
  localparam logic [4:0] PCL_GEN     = 5'h02;
  localparam logic [4:0] CYC_EXT     = 5'h03;
  localparam logic [4:0] CYC_EARLY   = 5'h02;
  localparam logic [4:0] PER_DIV     = 5'h04;
endpackage

// *** src/barb_sync3.sv ***
/*
  Three-flop synchroniser for a pin, idle high.
  Assumes the pin is asynchronous to clk_sys.
*/
`timescale 1ns/1ps
module barb_sync3 (
  input  wire logic clk_sys,
  input  wire logic rst,
  input  wire logic async_in,
  output logic      level_out
);
  logic s1_reg;
  logic s2_reg;
  logic s3_reg;
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      s1_reg    <= 1'b1;
      s2_reg    <= 1'b1;
      s3_reg    <= 1'b1;
      level_out <= 1'b1;
    end else begin
      s1_reg <= async_in;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      if (s2_reg == s3_reg) begin
        level_out <= s3_reg;
      end
    end
  end
endmodule

// *** verification/barb_ext_master.sv ***
/*
  Model of the external bus master that asks for the external bus.
  Assumes the block samples the request pin on clk_sys.
*/
`timescale 1ns/1ps
module barb_ext_master (
  input  wire logic clk_sys,
  input  wire logic rst,
  input  wire logic want,
  input  wire logic ack_n,
  input  wire logic cancel_n,
  output logic      req_n
);
  // ----------------------------------------
  // Request pin, idle high
  // ----------------------------------------
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      req_n <= 1'b1;
    end else begin
      req_n <= !((want || !ack_n) && cancel_n);
    end
  end
endmodule

// *** verification/tb.sv ***
/*
  Self-checking bench of the bus arbiter: access lengths, buffers, priority, bus release.
  Assumes the hand-over latencies: grant, issue, length, then a done pulse.
*/
`timescale 1ns/1ps
module tb;
  logic        CLK_SYS = 1'b0, RST = 1'b1, AVS_READ = 1'b0, AVS_WRITE = 1'b0, want = 1'b0;
  logic        CPU_SLEEP = 1'b0, DMA_SINGLE = 1'b0, AVS_WAITREQUEST, EXT_RELEASE_REQUEST_N;
  logic        RELEASE_ACK_N, RELEASE_CANCEL_REQUEST_N, RELEASE_CANCEL_OE, EXT_BUS_OE;
  logic [3:0]  AVS_ADDRESS = 4'h0, AVS_BYTEENABLE = 4'hf;
  logic [31:0] AVS_WRITEDATA = 32'h0, AVS_READDATA, rd;
  logic [2:0]  MST_REQ = 3'h0, MST_WRITE = 3'h0, MST_HOLD = 3'h0, MST_GRANT, MST_DONE;
  logic [8:0]  MST_SPACE = 9'h0;
  int          n_mismatch = 0, samples_checked = 0, n, i;
  // Space, write, shortest and longest request-to-done count
  int          rows [14][4] = '{'{0,0,3,3}, '{0,1,8,8}, '{1,0,3,3}, '{1,1,3,3}, '{2,1,4,4}, '{2,0,4,4},
    '{3,0,4,4}, '{3,1,5,5}, '{4,0,10,13}, '{4,1,14,17}, '{5,1,10,13}, '{5,0,10,13}, '{6,0,5,5}, '{6,1,5,5}};
  barb_arbiter i_barb_arbiter (.CLK_SYS, .RST, .AVS_ADDRESS, .AVS_READ, .AVS_WRITE, .AVS_WRITEDATA,
    .AVS_BYTEENABLE, .AVS_READDATA, .AVS_WAITREQUEST, .MST_REQ, .MST_WRITE, .MST_SPACE, .MST_HOLD,
    .CPU_SLEEP, .DMA_SINGLE, .MST_GRANT, .MST_DONE, .EXT_RELEASE_REQUEST_N, .RELEASE_ACK_N,
    .RELEASE_CANCEL_REQUEST_N, .RELEASE_CANCEL_OE, .EXT_BUS_OE);
  barb_ext_master i_barb_ext_master (.clk_sys(CLK_SYS), .rst(RST), .want(want), .ack_n(RELEASE_ACK_N),
    .cancel_n(RELEASE_CANCEL_REQUEST_N), .req_n(EXT_RELEASE_REQUEST_N));
  initial begin
    forever #25 CLK_SYS = ~CLK_SYS;
  end
  // ----------------------------------------
  // Report and helpers
  // ----------------------------------------
  task tally_and_finish;
    if (n_mismatch == 0 && samples_checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task chk(input bit ok, input string m);
    samples_checked++;
    if (!ok) begin
      n_mismatch++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask
  task need(input bit ok, input string m);
    chk(ok, m);
    if (!ok) tally_and_finish;
  endtask
  // Avalon cycle, entered just after a rising edge
  task av(input bit w, input logic [3:0] a, input logic [31:0] d);
    AVS_ADDRESS   <= a;
    AVS_WRITEDATA <= d;
    AVS_WRITE     <= w;
    AVS_READ      <= !w;
    n = 0;
    do begin
      @(posedge CLK_SYS);
      n++;
    end while (AVS_WAITREQUEST !== 1'b0 && n < 20);
    rd = AVS_READDATA;
    AVS_WRITE <= 1'b0;
    AVS_READ  <= 1'b0;
    need(n < 20, "bus timeout");
    @(posedge CLK_SYS);
  endtask
  task wdone(input int m);
    n = 0;
    do begin
      @(posedge CLK_SYS);
      #1;
      n++;
    end while (MST_DONE[m] !== 1'b1 && n < 60);
    need(n < 60, "no done");
    @(posedge CLK_SYS);
    MST_REQ[m] <= 1'b0;
  endtask
  task acc(input int m, input logic [2:0] sp, input bit w, input int lo, input int hi);
    MST_SPACE[3*m +: 3] <= sp;
    MST_WRITE[m]        <= w;
    MST_REQ[m]          <= 1'b1;
    wdone(m);
    chk(n >= lo && n <= hi, "access length");
    repeat (3) @(posedge CLK_SYS);
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (10) @(posedge CLK_SYS);
    chk(MST_GRANT === 3'h0 && RELEASE_ACK_N === 1'b1 && EXT_BUS_OE === 1'b1, "reset outputs");
    RST <= 1'b0;
    @(posedge CLK_SYS);
    av(0, barb_pkg::OFS_STATUS, 32'h0);
    chk(rd === 32'h0, "status reset value");
    av(0, 4'h2, 32'h0);
    chk(rd === 32'h0, "unmapped read");
    for (i = 0; i < 14; i++) acc(2, rows[i][0], rows[i][1], rows[i][2], rows[i][3]);
    av(1, barb_pkg::OFS_CTRL_TWO, 32'h1);
    acc(2, barb_pkg::SP_GEN_REG, 1, 4, 4);
    repeat (8) @(posedge CLK_SYS);
    acc(2, barb_pkg::SP_PFC_REG, 1, 14, 17);
    av(1, barb_pkg::OFS_CTRL_ONE, 32'h4);
    acc(2, barb_pkg::SP_EXT, 1, 4, 4);
    MST_SPACE <= 9'h049;
    MST_WRITE <= 3'h0;
    MST_REQ   <= 3'h5;
    @(posedge CLK_SYS);
    #1;
    chk(MST_GRANT === barb_pkg::GNT_DMA, "core granted over dma");
    wdone(2);
    wdone(0);
    av(1, barb_pkg::OFS_CTRL_TWO, 32'h2);
    MST_REQ <= 3'h5;
    wdone(2);
    #1;
    chk(MST_GRANT === barb_pkg::GNT_CPU, "core not alternated in");
    wdone(0);
    MST_HOLD <= 3'h1;
    @(posedge CLK_SYS);
    MST_REQ <= 3'h1;
    @(posedge CLK_SYS);
    MST_REQ[2] <= 1'b1;
    wdone(0);
    #1;
    chk(MST_GRANT === barb_pkg::GNT_CPU, "held bus taken");
    wdone(2);
    MST_HOLD <= 3'h0;
    av(1, barb_pkg::OFS_CTRL_ONE, 32'h3);
    want <= 1'b1;
    repeat (12) @(posedge CLK_SYS);
    chk(RELEASE_ACK_N === 1'b1, "released without pin enable");
    av(1, barb_pkg::OFS_PIN_CTRL, 32'h1);
    for (n = 0; n < 40 && RELEASE_ACK_N !== 1'b0; n++) begin @(posedge CLK_SYS); #1; end
    need(n < 40, "no release");
    chk(EXT_BUS_OE === 1'b0 && RELEASE_CANCEL_OE === 1'b1, "bus not floated");
    @(posedge CLK_SYS);
    acc(1, barb_pkg::SP_RAM, 0, 3, 3);
    MST_SPACE[8:6] <= barb_pkg::SP_EXT;
    MST_WRITE[2]   <= 1'b0;
    MST_REQ[2]     <= 1'b1;
    for (n = 0; n < 20 && RELEASE_CANCEL_REQUEST_N !== 1'b0; n++) begin @(posedge CLK_SYS); #1; end
    chk(n < 20 && RELEASE_ACK_N === 1'b0 && MST_DONE[2] === 1'b0, "no cancel request");
    @(posedge CLK_SYS);
    want <= 1'b0;
    for (n = 0; n < 40 && RELEASE_ACK_N !== 1'b1; n++) begin
      chk(MST_DONE[2] === 1'b0 && RELEASE_CANCEL_REQUEST_N === 1'b0, "access during release");
      @(posedge CLK_SYS);
      #1;
    end
    need(n < 40, "release never ends");
    chk(RELEASE_CANCEL_REQUEST_N === 1'b1 && EXT_BUS_OE === 1'b1, "cancel not cleared");
    wdone(2);
    tally_and_finish;
  end
endmodule
